// ---- hw/ppcfg_top.v ----
// Purpose: configuration logical device of a parallel port
// Assumes: one clock, synchronous active-high reset
// Notes: runtime port logic lives outside; this block gates it
//
// Operation
// - reset loads port configuration F2h
// - bit 4 clear blocks 403h-405h access
// - bit 1 clear gates off port clock
// - bit 0 set floats outputs when inactive
// - interrupt kind bit 0 shows mode
// - mode comes from mode control register
// - mode selects decoded registers, address bits
// - 13 registers over 12 entries decoded
// - four indirect extended-mode registers provided
// - base high bits 7:3 read zero
// - base low bits 1:0 read zero
// - index 75h always reads 04h
// - inactive device blocks runtime access
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ppcfg_top (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] cfgAddr,
  input wire [7:0] cfgWrData,
  input wire cfgWrite,
  input wire cfgRead,
  output reg [7:0] cfgRdData,
  input wire [15:0] rtAddr,
  input wire [7:0] rtWrData,
  input wire rtWrite,
  input wire rtRead,
  output reg [7:0] rtRdData,
  output reg rtHit,
  output reg portClockEnable,
  output reg portFloat,
  output reg portActive,
  output reg [15:0] portBase,
  output reg [7:0] portIrqNumber,
  output reg portIrqLevel,
  output reg [7:0] portDmaChannel,
  output reg [2:0] portMode
);
  `include "ppcfg_map.vh"
  reg [7:0] portActivate;
  reg [7:0] baseAddressHigh;
  reg [7:0] baseAddressLow;
  reg [7:0] interruptLineNumber;
  reg [7:0] interruptKind;
  reg [7:0] dmaChannelChoice;
  reg [7:0] portConfiguration;
  reg [7:0] portModeControlRegister;
  reg [7:0] extReg [0:3];
  reg [7:0] next_cfgRdData;
  reg [7:0] next_rtRdData;
  reg next_rtHit;
  wire hitStd;
  wire hitModeCtrl;
  wire hitExt;
  wire [1:0] extSel;
  wire [2:0] modeNow;
  wire activeNow;
  wire extMode;
  wire [1:0] extIndex;
  assign modeNow = portModeControlRegister[`PPCFG_MODE_MSB:`PPCFG_MODE_LSB];
  assign activeNow = portActivate[`PPCFG_BIT_ACTIVE];
  assign extMode = (modeNow == `PPCFG_MODE_EXTENDED);
  // ===========================================================
  // runtime decode
  ppcfg_rt_decode ppcfg_rt_decode_i (
    .rtAddr(rtAddr),
    .baseAddr({baseAddressHigh, baseAddressLow}),
    .portMode(modeNow),
    .active(activeNow),
    .extAccess(portConfiguration[`PPCFG_BIT_EXT_ACCESS]),
    .hitStd(hitStd),
    .hitModeCtrl(hitModeCtrl),
    .hitExt(hitExt),
    .extSel(extSel)
  );
  // entry 405h holds the second-level offset; 404h is the indirect data window
  assign extIndex = extReg[2][1:0];
  // ===========================================================
  // configuration registers
  always @(posedge ref_clk) begin
    if (reset) begin
      portActivate <= `PPCFG_RST_ACTIVATE;
      baseAddressHigh <= `PPCFG_RST_BASE_HIGH;
      baseAddressLow <= `PPCFG_RST_BASE_LOW;
      interruptLineNumber <= `PPCFG_RST_IRQ_NUM;
      interruptKind <= `PPCFG_RST_IRQ_KIND;
      dmaChannelChoice <= `PPCFG_RST_DMA;
      portConfiguration <= `PPCFG_RST_PORT_CFG;
    end else if (cfgWrite) begin
      if (cfgAddr == `PPCFG_IDX_ACTIVATE) begin
        portActivate <= cfgWrData;
      end else if (cfgAddr == `PPCFG_IDX_BASE_HIGH) begin
        baseAddressHigh <= cfgWrData & `PPCFG_MASK_BASE_HIGH;
      end else if (cfgAddr == `PPCFG_IDX_BASE_LOW) begin
        baseAddressLow <= cfgWrData & `PPCFG_MASK_BASE_LOW;
      end else if (cfgAddr == `PPCFG_IDX_IRQ_NUM) begin
        interruptLineNumber <= cfgWrData;
      end else if (cfgAddr == `PPCFG_IDX_IRQ_KIND) begin
        interruptKind <= cfgWrData & `PPCFG_MASK_IRQ_KIND;
      end else if (cfgAddr == `PPCFG_IDX_DMA) begin
        dmaChannelChoice <= cfgWrData;
      end else if (cfgAddr == `PPCFG_IDX_PORT_CFG) begin
        // bits 7:5 kept as written (software keeps them ones)
        portConfiguration <= cfgWrData & `PPCFG_MASK_PORT_CFG;
      end
    end
  end
  // ===========================================================
  // configuration read
  always @* begin
    next_cfgRdData = 8'h00;
    if (cfgAddr == `PPCFG_IDX_ACTIVATE) begin
      next_cfgRdData = portActivate;
    end else if (cfgAddr == `PPCFG_IDX_BASE_HIGH) begin
      next_cfgRdData = baseAddressHigh;
    end else if (cfgAddr == `PPCFG_IDX_BASE_LOW) begin
      next_cfgRdData = baseAddressLow;
    end else if (cfgAddr == `PPCFG_IDX_IRQ_NUM) begin
      next_cfgRdData = interruptLineNumber;
    end else if (cfgAddr == `PPCFG_IDX_IRQ_KIND) begin
      next_cfgRdData = {interruptKind[7:1], extMode};
    end else if (cfgAddr == `PPCFG_IDX_DMA) begin
      next_cfgRdData = dmaChannelChoice;
    end else if (cfgAddr == `PPCFG_IDX_DMA2) begin
      next_cfgRdData = `PPCFG_VAL_DMA2;
    end else if (cfgAddr == `PPCFG_IDX_PORT_CFG) begin
      next_cfgRdData = portConfiguration;
    end
  end
  // ===========================================================
  // runtime registers owned here
  // mode control keeps its value with the clock gated, as registers are maintained
  always @(posedge ref_clk) begin
    if (reset) begin
      portModeControlRegister <= `PPCFG_RST_MODE_CTRL;
    end else if (rtWrite && hitModeCtrl) begin
      portModeControlRegister <= rtWrData;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gExt
      always @(posedge ref_clk) begin
        if (reset) begin
          extReg[gi] <= 8'h00;
        end else if (rtWrite && hitExt) begin
          if (gi < 3 && {30'h0, extSel} == gi) begin
            extReg[gi] <= rtWrData;
          end else if (gi == 3 && extSel == 2'h1 && extIndex == 2'h3) begin
            extReg[gi] <= rtWrData;
          end
        end
      end
    end
  endgenerate
  // ===========================================================
  // runtime read; blocked accesses return zero and no hit
  always @* begin
    next_rtRdData = 8'h00;
    next_rtHit = 1'b0;
    if (rtRead) begin
      if (hitModeCtrl) begin
        next_rtRdData = portModeControlRegister;
        next_rtHit = 1'b1;
      end else if (hitExt) begin
        next_rtHit = 1'b1;
        if (extSel == 2'h1) begin
          next_rtRdData = extReg[{1'b0, extIndex[0]} + (extIndex[1] ? 2'h2 : 2'h0)];
        end else begin
          next_rtRdData = extReg[extSel];
        end
      end else if (hitStd) begin
        next_rtHit = 1'b1;
      end
    end
  end
  // ===========================================================
  // registered outputs
  always @(posedge ref_clk) begin
    if (reset) begin
      cfgRdData <= 8'h00;
      rtRdData <= 8'h00;
      rtHit <= 1'b0;
      portClockEnable <= 1'b0;
      portFloat <= 1'b0;
      portActive <= 1'b0;
      portBase <= 16'h0000;
      portIrqNumber <= 8'h00;
      portIrqLevel <= 1'b0;
      portDmaChannel <= 8'h00;
      portMode <= 3'h0;
    end else begin
      cfgRdData <= cfgRead ? next_cfgRdData : 8'h00;
      rtRdData <= next_rtRdData;
      rtHit <= next_rtHit;
      portClockEnable <= activeNow && portConfiguration[`PPCFG_BIT_CLOCK_ON];
      portFloat <= !activeNow && portConfiguration[`PPCFG_BIT_FLOAT];
      portActive <= activeNow;
      portBase <= {baseAddressHigh, baseAddressLow};
      portIrqNumber <= interruptLineNumber;
      portIrqLevel <= extMode;
      portDmaChannel <= dmaChannelChoice;
      portMode <= modeNow;
    end
  end
endmodule // ppcfg_top
`default_nettype wire

// ---- hw/ppcfg_map.vh ----
// Purpose: constants for the parallel port configuration block
// Assumes: 8-bit configuration index space, 16-bit runtime address
// Notes: definitions only
`ifndef PPCFG_MAP_VH
`define PPCFG_MAP_VH
// ===========================================================
// configuration indexes
`define PPCFG_IDX_ACTIVATE 8'h30
`define PPCFG_IDX_BASE_HIGH 8'h60
`define PPCFG_IDX_BASE_LOW 8'h61
`define PPCFG_IDX_IRQ_NUM 8'h70
`define PPCFG_IDX_IRQ_KIND 8'h71
`define PPCFG_IDX_DMA 8'h74
`define PPCFG_IDX_DMA2 8'h75
`define PPCFG_IDX_PORT_CFG 8'hF0
// ===========================================================
// reset values
`define PPCFG_RST_ACTIVATE 8'h00
`define PPCFG_RST_BASE_HIGH 8'h02
`define PPCFG_RST_BASE_LOW 8'h78
`define PPCFG_RST_IRQ_NUM 8'h07
`define PPCFG_RST_IRQ_KIND 8'h02
`define PPCFG_RST_DMA 8'h04
`define PPCFG_VAL_DMA2 8'h04
`define PPCFG_RST_PORT_CFG 8'hF2
// ===========================================================
// field masks and positions
`define PPCFG_MASK_BASE_HIGH 8'h07
`define PPCFG_MASK_BASE_LOW 8'hFC
`define PPCFG_MASK_IRQ_KIND 8'h02
`define PPCFG_MASK_PORT_CFG 8'hF3
`define PPCFG_BIT_EXT_ACCESS 4
`define PPCFG_BIT_CLOCK_ON 1
`define PPCFG_BIT_FLOAT 0
`define PPCFG_BIT_ACTIVE 0
// ===========================================================
// runtime offsets and mode field
`define PPCFG_OFS_MODE_CTRL 12'h402
`define PPCFG_OFS_EXT_A 12'h403
`define PPCFG_OFS_EXT_B 12'h404
`define PPCFG_OFS_EXT_C 12'h405
`define PPCFG_MODE_MSB 7
`define PPCFG_MODE_LSB 5
`define PPCFG_MODE_EPP 3'h4
`define PPCFG_MODE_EXTENDED 3'h7
`define PPCFG_RST_MODE_CTRL 8'h00
`endif

// ---- hw/ppcfg_rt_decode.v ----
// Purpose: runtime address decode for the parallel port
// Assumes: inputs synchronous to the caller's clock
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module ppcfg_rt_decode (
  input wire [15:0] rtAddr,
  input wire [15:0] baseAddr,
  input wire [2:0] portMode,
  input wire active,
  input wire extAccess,
  output reg hitStd,
  output reg hitModeCtrl,
  output reg hitExt,
  output reg [1:0] extSel
);
  `include "ppcfg_map.vh"
  reg [15:0] stdMask;
  reg [11:0] ofs;
  reg [15:0] hiBase;
  // ===========================================================
  // decode
  always @* begin
    // epp mode spans eight bytes, others four
    if (portMode == `PPCFG_MODE_EPP) begin
      stdMask = 16'hFFF8;
    end else begin
      stdMask = 16'hFFFC;
    end
    hiBase = baseAddr + 16'h0400;
    ofs = rtAddr[11:0] - baseAddr[11:0];
    hitStd = active && ((rtAddr & stdMask) == (baseAddr & stdMask));
    hitModeCtrl = 1'b0;
    hitExt = 1'b0;
    extSel = 2'h0;
    if (active && rtAddr[15:3] == hiBase[15:3]) begin
      if (ofs == `PPCFG_OFS_MODE_CTRL) begin
        hitModeCtrl = 1'b1;
      end else if (extAccess && portMode == `PPCFG_MODE_EXTENDED) begin
        if (ofs == `PPCFG_OFS_EXT_A) begin
          hitExt = 1'b1;
          extSel = 2'h0;
        end else if (ofs == `PPCFG_OFS_EXT_B) begin
          hitExt = 1'b1;
          extSel = 2'h1;
        end else if (ofs == `PPCFG_OFS_EXT_C) begin
          hitExt = 1'b1;
          extSel = 2'h2;
        end
      end
    end
  end
endmodule // ppcfg_rt_decode
`default_nettype wire

// ---- test/ppcfg_monitor.sv ----
// Purpose: port-level checks of the parallel port configuration block
// Assumes: one clock, sync active-high reset
// Notes: read data checked in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// checker
module ppcfg_monitor (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] cfgAddr,
  input wire logic cfgRead,
  input wire logic [7:0] cfgRdData,
  input wire logic rtRead,
  input wire logic rtHit,
  input wire logic portClockEnable,
  input wire logic portFloat,
  input wire logic portActive,
  input wire logic portIrqLevel,
  input wire logic [2:0] portMode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_rd(logic [7:0] idx);
    cfgRead && cfgAddr == idx;
  endsequence
  AST_SECOND_DMA: assert property (s_rd(8'h75) |=> cfgRdData == 8'h04)
    else $error("second dma index not 04");
  AST_BASE_HIGH: assert property (s_rd(8'h60) |=> cfgRdData[7:3] == 5'h00)
    else $error("base high upper bits not zero");
  AST_BASE_LOW: assert property (s_rd(8'h61) |=> cfgRdData[1:0] == 2'h0)
    else $error("base low lower bits not zero");
  AST_CFG_RSVD: assert property (s_rd(8'hF0) |=> cfgRdData[3:2] == 2'h0)
    else $error("reserved config bits not zero");
  AST_IRQ_KIND: assert property (s_rd(8'h71) |=> cfgRdData[0] == portIrqLevel)
    else $error("interrupt kind bit0 differs from level output");
  AST_LEVEL_MODE: assert property (portIrqLevel == (portMode == 3'h7))
    else $error("level interrupt not tied to extended mode");
  AST_CLOCK_GATE: assert property (portClockEnable |-> portActive)
    else $error("port clock on while inactive");
  AST_FLOAT: assert property (portFloat |-> !portActive)
    else $error("outputs float while active");
  AST_RT_ACTIVE: assert property (rtHit |-> $past(rtRead) && portActive)
    else $error("runtime hit without read or while inactive");
endmodule // ppcfg_monitor
bind ppcfg_top ppcfg_monitor ppcfg_monitor_i (.ref_clk(ref_clk), .reset(reset),
  .cfgAddr(cfgAddr), .cfgRead(cfgRead), .cfgRdData(cfgRdData), .rtRead(rtRead),
  .rtHit(rtHit), .portClockEnable(portClockEnable), .portFloat(portFloat),
  .portActive(portActive), .portIrqLevel(portIrqLevel), .portMode(portMode));
`default_nettype wire

// ---- test/ppcfg_periph_model.sv ----
// Purpose: peripheral on the port pins
// Assumes: pull-up on the observed pin
// Notes: a driven pin changes every cycle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// peripheral
module ppcfg_periph_model (
  input wire logic ref_clk,
  input wire logic portFloat,
  output logic pinLevel
);
  logic pattern = 1'b0;
  always @(posedge ref_clk) pattern <= ~pattern;
  // floated pin falls to the pull-up level
  assign pinLevel = portFloat ? 1'b1 : pattern;
endmodule // ppcfg_periph_model
`default_nettype wire

// ---- test/test_parallel_port_config.sv ----
// Purpose: self-checking bench for the configuration block
// Assumes: base left at 0278h for runtime accesses
// Notes: random config traffic plus runtime corner cases
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench
module test_parallel_port_config;
  logic ref_clk = 1'b0, reset = 1'b1, cfgWrite = 1'b0, cfgRead = 1'b0;
  logic rtWrite = 1'b0, rtRead = 1'b0;
  logic [7:0] cfgAddr = 8'h00, cfgWrData = 8'h00, rtWrData = 8'h00;
  logic [15:0] rtAddr = 16'h0000;
  logic [7:0] cfgRdData, rtRdData, portIrqNumber, portDmaChannel, d, w, a;
  logic [15:0] portBase;
  logic [2:0] portMode;
  logic rtHit, portClockEnable, portFloat, portActive, portIrqLevel, pinLevel;
  int fails = 0, total_checks = 0, n;
  logic [7:0] idx [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0, 8'h31};
  logic [7:0] rstv [9] = '{8'h00, 8'h02, 8'h78, 8'h07, 8'h02, 8'h04, 8'h04, 8'hF2, 8'h00};
  ppcfg_top ppcfg_top_i (.ref_clk(ref_clk), .reset(reset), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgRdData(cfgRdData),
    .rtAddr(rtAddr), .rtWrData(rtWrData), .rtWrite(rtWrite), .rtRead(rtRead),
    .rtRdData(rtRdData), .rtHit(rtHit), .portClockEnable(portClockEnable),
    .portFloat(portFloat), .portActive(portActive), .portBase(portBase),
    .portIrqNumber(portIrqNumber), .portIrqLevel(portIrqLevel),
    .portDmaChannel(portDmaChannel), .portMode(portMode));
  ppcfg_periph_model ppcfg_periph_model_i (.ref_clk(ref_clk), .portFloat(portFloat),
    .pinLevel(pinLevel));
  always #10 ref_clk = ~ref_clk;
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cw(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge ref_clk);
    cfgAddr <= ad;
    cfgWrData <= wd;
    cfgWrite <= 1'b1;
    @(posedge ref_clk);
    cfgWrite <= 1'b0;
  endtask
  task automatic cr(input logic [7:0] ad, output logic [7:0] rd);
    @(posedge ref_clk);
    cfgAddr <= ad;
    cfgRead <= 1'b1;
    @(posedge ref_clk);
    cfgRead <= 1'b0;
    #1 rd = cfgRdData;
  endtask
  task automatic rw(input logic [15:0] ad, input logic [7:0] wd);
    @(posedge ref_clk);
    rtAddr <= ad;
    rtWrData <= wd;
    rtWrite <= 1'b1;
    @(posedge ref_clk);
    rtWrite <= 1'b0;
  endtask
  task automatic rr(input logic [15:0] ad, input logic [7:0] exp, input logic hit);
    @(posedge ref_clk);
    rtAddr <= ad;
    rtRead <= 1'b1;
    @(posedge ref_clk);
    rtRead <= 1'b0;
    #1 chk("runtime data", rtRdData, exp);
    chk("runtime hit", {7'h00, rtHit}, {7'h00, hit});
  endtask
  // outputs lag their registers by one cycle
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [7:0] expc(input logic [7:0] ad, input logic [7:0] wd);
    case (ad)
      8'h60: expc = wd & 8'h07;
      8'h61: expc = wd & 8'hFC;
      8'h71: expc = wd & 8'h02;
      8'h75: expc = 8'h04;
      8'hF0: expc = wd & 8'hF3;
      8'h31: expc = 8'h00;
      default: expc = wd;
    endcase
  endfunction
  task automatic wrap_up;
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(7622));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (n = 0; n < 9; n++) begin
      cr(idx[n], d);
      chk("reset value", d, rstv[n]);
    end
    for (n = 0; n < 60; n++) begin
      a = idx[$urandom_range(8, 1)];
      w = $urandom;
      if (a == 8'hF0) w[7:5] = 3'b111;
      if (a == 8'h60) w[2] = 1'b0;
      cw(a, w);
      cr(a, d);
      chk("config readback", d, expc(a, w));
    end
    cw(8'h60, 8'h02);
    cw(8'h61, 8'h78);
    cw(8'h71, 8'h02);
    cw(8'hF0, 8'hE1);
    cw(8'h70, 8'h05);
    cw(8'h74, 8'h03);
    settle();
    chk("float inactive", {7'h00, portFloat}, 8'h01);
    chk("pin pulled up", {7'h00, pinLevel}, 8'h01);
    chk("active off", {7'h00, portActive}, 8'h00);
    chk("base high", portBase[15:8], 8'h02);
    chk("base low", portBase[7:0], 8'h78);
    chk("irq number", portIrqNumber, 8'h05);
    chk("dma channel", portDmaChannel, 8'h03);
    rr(16'h067A, 8'h00, 1'b0);
    rr(16'h0279, 8'h00, 1'b0);
    rw(16'h067A, 8'hE0);
    cw(8'h30, 8'h01);
    settle();
    chk("float active", {7'h00, portFloat}, 8'h00);
    chk("clock gated", {7'h00, portClockEnable}, 8'h00);
    chk("active on", {7'h00, portActive}, 8'h01);
    rr(16'h067A, 8'h00, 1'b1);
    rr(16'h0279, 8'h00, 1'b1);
    rr(16'h027D, 8'h00, 1'b0);
    rw(16'h067A, 8'hE0);
    rr(16'h067B, 8'h00, 1'b0);
    cw(8'hF0, 8'hF2);
    settle();
    chk("clock on", {7'h00, portClockEnable}, 8'h01);
    chk("mode", {5'h00, portMode}, 8'h07);
    cr(8'h71, d);
    chk("level kind", d, 8'h03);
    rw(16'h067B, 8'h5A);
    rr(16'h067B, 8'h5A, 1'b1);
    rw(16'h067D, 8'h00);
    rr(16'h067C, 8'h5A, 1'b1);
    rw(16'h067A, 8'h80);
    rr(16'h067B, 8'h00, 1'b0);
    rr(16'h027D, 8'h00, 1'b1);
    cr(8'h71, d);
    chk("edge kind", d, 8'h02);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    cr(8'hF0, d);
    chk("port config after reset", d, 8'hF2);
    cr(8'h30, d);
    chk("activate after reset", d, 8'h00);
    wrap_up();
  end
endmodule // test_parallel_port_config
`default_nettype wire
